// ---- eep_pkg.sv ----
// Constants shared by the nonvolatile data array access port
package eep_pkg;
    // ========================================================
    // Geometry
    localparam int unsigned ADDR_W    = 9;
    localparam int unsigned DATA_W    = 8;
    localparam int unsigned DEPTH     = 512;
    localparam int unsigned IO_ADDR_W = 6;

    // ========================================================
    // I/O space offsets
    localparam logic [5:0] OFS_CONTROL      = 6'h1f;
    localparam logic [5:0] OFS_DATA         = 6'h20;
    localparam logic [5:0] OFS_ADDRESS_LOW  = 6'h21;
    localparam logic [5:0] OFS_ADDRESS_HIGH = 6'h22;

    // ========================================================
    // Control register fields
    localparam int unsigned BIT_READ_STROBE  = 0;
    localparam int unsigned BIT_WRITE_STROBE = 1;
    localparam int unsigned BIT_MASTER_WE    = 2;

    // ========================================================
    // Reset values
    localparam logic [8:0] RST_ADDRESS = 9'h000;
    localparam logic [7:0] RST_DATA    = 8'h00;

    // ========================================================
    // Timing counts in core_clk cycles
    localparam logic [2:0] STALL_READ_CYCLES  = 3'h4;
    localparam logic [2:0] STALL_WRITE_CYCLES = 3'h2;
    localparam logic [2:0] MASTER_WE_CYCLES   = 3'h4;
    // Write time in calibrated oscillator cycles
    localparam int unsigned WRITE_OSC_CYCLES_DEF = 67584;
    localparam int unsigned OSC_CNT_W            = 17;

    typedef enum logic [0:0] {
        EEP_IDLE    = 1'b0,
        EEP_PROGRAM = 1'b1
    } eep_state_e;
endpackage : eep_pkg

// ---- eep_arr_if.sv ----
// Connection between the access port and the byte array
`timescale 1ns/1ps
interface eep_arr_if;
    logic [8:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic [7:0] rdata;
    modport ctrl  (output addr, output wdata, output we, input rdata);
    modport store (input addr, input wdata, input we, output rdata);
endinterface : eep_arr_if

// ---- eep_array_store.sv ----
// Byte-wide nonvolatile data array held in flip-flops
`timescale 1ns/1ps
module eep_array_store
    import eep_pkg::*;
(
    input wire logic core_clk,
    eep_arr_if.store arr
);
    // ========================================================
    // Storage, no reset: contents survive like the real array
    logic [7:0] mem [DEPTH];
    logic [7:0] next_mem [DEPTH];

    always_comb begin
        next_mem = mem;
        if (arr.we) begin
            next_mem[arr.addr] = arr.wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        mem <= next_mem;
    end

    assign arr.rdata = mem[arr.addr];
endmodule : eep_array_store

// ---- eep_access_port.sv ----
// CPU I/O-space access port to the 512-byte nonvolatile data array
// Contract
// - 512 bytes, linear addresses 0 to 511
// - Address bit 8 high, bits 7..0 low
// - Address high bits 15..9 read zero
// - Write programs data byte at address
// - Read loads data register from array
// - Read stalls CPU four cycles
// - Write start stalls CPU two cycles
// - Busy strobe shows when next write allowed
// - Write needs guarded master-enable sequence
// - Registers live in I/O space
// - Control bits 7..4 read zero
// - Master enable self-clears after four cycles
// - Write strobe without master enable does nothing
// - Write strobe stays set until done
// - Busy write blocks reads and address changes
`timescale 1ns/1ps
module eep_access_port
    import eep_pkg::*;
#(
    parameter int unsigned WRITE_OSC_CYCLES = WRITE_OSC_CYCLES_DEF
) (
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic [5:0] io_addr,
    input  wire logic       io_wr,
    input  wire logic       io_rd,
    input  wire logic [7:0] io_wdata,
    input  wire logic       osc_pin,
    output logic      [7:0] io_rdata,
    output logic            cpu_stall,
    output logic            write_busy
);
    // ========================================================
    // State
    eep_state_e             state,        next_state;
    logic [8:0]             nv_address,   next_nv_address;
    logic [7:0]             nv_data,      next_nv_data;
    logic [7:0]             prog_data,    next_prog_data;
    logic                   master_write_enable, next_master_write_enable;
    logic [2:0]             mwe_cnt,      next_mwe_cnt;
    logic [2:0]             stall_cnt,    next_stall_cnt;
    logic [OSC_CNT_W-1:0]   osc_cnt,      next_osc_cnt;
    logic [7:0]             next_io_rdata;
    logic                   next_cpu_stall;
    logic [2:0]             osc_sync;
    logic                   osc_tick;
    logic                   wr_ctrl, start_write, start_read, write_done;

    eep_arr_if arr ();

    eep_array_store u_store (
        .core_clk (core_clk),
        .arr      (arr)
    );

    // ========================================================
    // Oscillator crossing; only stage 2 and 3 feed the edge detect
    assign osc_tick = osc_sync[1] & ~osc_sync[2];

    assign wr_ctrl     = io_wr && (io_addr == OFS_CONTROL);
    assign write_busy  = (state == EEP_PROGRAM);
    assign start_write = wr_ctrl && io_wdata[BIT_WRITE_STROBE]
                         && master_write_enable && !write_busy;
    // A simultaneous write start takes precedence over a read
    assign start_read  = wr_ctrl && io_wdata[BIT_READ_STROBE]
                         && !write_busy && !start_write;
    assign write_done  = write_busy && osc_tick
                         && (osc_cnt == OSC_CNT_W'(WRITE_OSC_CYCLES - 1));

    // Array is programmed at the end of the timed write
    assign arr.addr  = nv_address;
    assign arr.wdata = prog_data;
    assign arr.we    = write_done;

    function automatic logic [7:0] read_mux(input logic [5:0] a);
        unique case (a)
            OFS_CONTROL:      read_mux = {5'h00, master_write_enable,
                                          write_busy, 1'b0};
            OFS_DATA:         read_mux = nv_data;
            OFS_ADDRESS_LOW:  read_mux = nv_address[7:0];
            OFS_ADDRESS_HIGH: read_mux = {7'h00, nv_address[8]};
            default:          read_mux = 8'h00;
        endcase
    endfunction : read_mux

    // ========================================================
    // Next-state logic
    always_comb begin
        next_state               = state;
        next_nv_address          = nv_address;
        next_nv_data             = nv_data;
        next_prog_data           = prog_data;
        next_master_write_enable = master_write_enable;
        next_mwe_cnt             = mwe_cnt;
        next_stall_cnt           = stall_cnt;
        next_osc_cnt             = osc_cnt;
        next_io_rdata            = io_rd ? read_mux(io_addr) : io_rdata;

        if (stall_cnt != 3'h0) begin
            next_stall_cnt = stall_cnt - 3'h1;
        end
        // Master enable times out; a fresh set restarts the window
        if (mwe_cnt != 3'h0) begin
            next_mwe_cnt = mwe_cnt - 3'h1;
            if (mwe_cnt == 3'h1) begin
                next_master_write_enable = 1'b0;
            end
        end
        if (wr_ctrl && io_wdata[BIT_MASTER_WE]) begin
            next_master_write_enable = 1'b1;
            next_mwe_cnt             = MASTER_WE_CYCLES;
        end

        if (io_wr && !write_busy) begin
            if (io_addr == OFS_ADDRESS_LOW) begin
                next_nv_address[7:0] = io_wdata;
            end
            if (io_addr == OFS_ADDRESS_HIGH) begin
                next_nv_address[8] = io_wdata[0];
            end
        end
        if (io_wr && (io_addr == OFS_DATA)) begin
            next_nv_data = io_wdata;
        end

        if (start_read) begin
            next_nv_data   = arr.rdata;
            next_stall_cnt = STALL_READ_CYCLES;
        end

        unique case (state)
            EEP_IDLE: begin
                if (start_write) begin
                    next_state     = EEP_PROGRAM;
                    next_prog_data = nv_data;
                    next_osc_cnt   = '0;
                    next_stall_cnt = STALL_WRITE_CYCLES;
                end
            end
            EEP_PROGRAM: begin
                if (osc_tick) begin
                    next_osc_cnt = osc_cnt + OSC_CNT_W'(1);
                end
                if (write_done) begin
                    next_state = EEP_IDLE;
                end
            end
        endcase
        next_cpu_stall = (next_stall_cnt != 3'h0);
    end

    // ========================================================
    // Registers
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state               <= EEP_IDLE;
            nv_address          <= RST_ADDRESS;
            nv_data             <= RST_DATA;
            prog_data           <= RST_DATA;
            master_write_enable <= 1'b0;
            mwe_cnt             <= 3'h0;
            stall_cnt           <= 3'h0;
            osc_cnt             <= '0;
            io_rdata            <= 8'h00;
            cpu_stall           <= 1'b0;
            osc_sync            <= 3'h0;
        end else begin
            state               <= next_state;
            nv_address          <= next_nv_address;
            nv_data             <= next_nv_data;
            prog_data           <= next_prog_data;
            master_write_enable <= next_master_write_enable;
            mwe_cnt             <= next_mwe_cnt;
            stall_cnt           <= next_stall_cnt;
            osc_cnt             <= next_osc_cnt;
            io_rdata            <= next_io_rdata;
            cpu_stall           <= next_cpu_stall;
            osc_sync            <= {osc_sync[1:0], osc_pin};
        end
    end

    // ========================================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    chk_mwe_timeout: assert property (
        $rose(master_write_enable) && !wr_ctrl ##1 !wr_ctrl [*3]
        |-> master_write_enable ##1 !master_write_enable)
        else $error("master enable did not time out");
    chk_strobe_guard: assert property (
        wr_ctrl && io_wdata[BIT_WRITE_STROBE] && !master_write_enable && !write_busy
        |=> !write_busy)
        else $error("write started without master enable");
    chk_read_stall: assert property (
        start_read |=> cpu_stall [*4] ##1 (!cpu_stall || $past(io_wr)))
        else $error("read stall length wrong");
    chk_write_stall: assert property (
        start_write |=> cpu_stall [*2] ##1 !cpu_stall)
        else $error("write stall length wrong");
    chk_read_data: assert property (
        start_read |=> nv_data == $past(arr.rdata))
        else $error("read data not loaded");
    chk_addr_frozen: assert property (
        write_busy |=> nv_address == $past(nv_address))
        else $error("address changed during write");
    chk_read_refused: assert property (
        write_busy && !(io_wr && io_addr == OFS_DATA) |=> nv_data == $past(nv_data))
        else $error("data changed during write");
    chk_addr_high_zero: assert property (
        io_rd && io_addr == OFS_ADDRESS_HIGH |=> io_rdata[7:1] == 7'h00)
        else $error("reserved address bits not zero");
    chk_ctrl_high_zero: assert property (
        io_rd && io_addr == OFS_CONTROL |=> io_rdata[7:4] == 4'h0)
        else $error("reserved control bits not zero");
    // Address is frozen while busy, so the port still points at the programmed byte
    chk_write_commit: assert property (
        write_done |=> !write_busy && arr.rdata == $past(prog_data))
        else $error("array byte not programmed at write end");
endmodule : eep_access_port

// ---- eep_cpu_model.sv ----
// CPU core model issuing I/O register accesses to the access port
`timescale 1ns/1ps
module eep_cpu_model (
    input  wire logic       core_clk,
    input  wire logic       cpu_stall,
    input  wire logic [7:0] io_rdata,
    output logic      [5:0] io_addr,
    output logic            io_wr,
    output logic            io_rd,
    output logic      [7:0] io_wdata
);
    initial begin
        io_addr = 6'h3f;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = 8'ha5;
    end

    // ========================================================
    // Bus cycles; a halted core issues nothing until the stall ends
    task automatic io_write(input logic [5:0] a, input logic [7:0] d);
        @(posedge core_clk);
        while (cpu_stall === 1'b1) @(posedge core_clk);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= 1'b1;
        @(posedge core_clk);
        io_wr <= 1'b0;
        // Released lines show the inverse so stale data is never reused
        io_addr <= ~a;
        io_wdata <= ~d;
    endtask : io_write

    task automatic io_read(input logic [5:0] a, output logic [7:0] d);
        @(posedge core_clk);
        while (cpu_stall === 1'b1) @(posedge core_clk);
        io_addr <= a;
        io_rd <= 1'b1;
        @(posedge core_clk);
        io_rd <= 1'b0;
        io_addr <= ~a;
        @(posedge core_clk);
        d = io_rdata;
    endtask : io_read
endmodule : eep_cpu_model

// ---- test_eeprom_cpu_access_port.sv ----
// Self-checking testbench for the nonvolatile array access port
`timescale 1ns/1ps
module test_eeprom_cpu_access_port;
    import eep_pkg::*;
    logic       core_clk;
    logic       resetn;
    logic       osc_pin;
    logic [5:0] io_addr;
    logic       io_wr;
    logic       io_rd;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;
    logic       cpu_stall;
    logic       write_busy;
    logic [7:0] rd;
    logic [7:0] mem [int];
    int         failures;
    int         compares;
    int         n;
    int         a;

    // Short write time keeps the run brief
    eep_access_port #(.WRITE_OSC_CYCLES(4)) u_dut (.core_clk(core_clk), .resetn(resetn),
        .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
        .osc_pin(osc_pin), .io_rdata(io_rdata), .cpu_stall(cpu_stall),
        .write_busy(write_busy));
    eep_cpu_model u_cpu (.core_clk(core_clk), .cpu_stall(cpu_stall), .io_rdata(io_rdata),
        .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata));

    // ========================================================
    // Clocks, reset, watchdog
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // Oscillator far slower than core_clk so the synchroniser sees every tick
    initial begin
        osc_pin = 1'b0;
        forever #40 osc_pin = ~osc_pin;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        finish_test();
    end

    // ========================================================
    // Helpers
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic count_stall(output int c);
        c = 0;
        repeat (8) begin
            #1 c += (cpu_stall === 1'b1);
            @(posedge core_clk);
        end
    endtask : count_stall

    task automatic set_addr(input int ad);
        u_cpu.io_write(OFS_ADDRESS_HIGH, {7'h00, ad[8]});
        u_cpu.io_write(OFS_ADDRESS_LOW, ad[7:0]);
    endtask : set_addr

    task automatic nv_write(input int ad, input logic [7:0] d);
        int k;
        set_addr(ad);
        u_cpu.io_write(OFS_DATA, d);
        u_cpu.io_write(OFS_CONTROL, 8'h04);
        // Odd addresses also set the read strobe: the write must win
        u_cpu.io_write(OFS_CONTROL, {7'h01, ad[0]});
        count_stall(k);
        check(8'(k), 8'h02);
        check({7'h00, write_busy}, 8'h01);
        u_cpu.io_write(OFS_ADDRESS_LOW, ~ad[7:0]);
        u_cpu.io_read(OFS_CONTROL, rd);
        check(rd, 8'h02);
        u_cpu.io_write(OFS_CONTROL, 8'h01);
        count_stall(k);
        check(8'(k), 8'h00);
        k = 0;
        while (write_busy !== 1'b0 && k < 400) begin
            @(posedge core_clk);
            k++;
        end
        check({7'h00, write_busy}, 8'h00);
        u_cpu.io_read(OFS_ADDRESS_LOW, rd);
        check(rd, 8'(ad));
        mem[ad] = d;
    endtask : nv_write

    task automatic nv_read(input int ad);
        int k;
        set_addr(ad);
        u_cpu.io_write(OFS_CONTROL, 8'h01);
        count_stall(k);
        check(8'(k), 8'h04);
        u_cpu.io_read(OFS_DATA, rd);
        check(rd, mem[ad]);
    endtask : nv_read

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test

    // ========================================================
    // Main sequence
    initial begin
        failures = 0;
        compares = 0;
        resetn = 1'b0;
        repeat (4) @(posedge core_clk);
        resetn <= 1'b1;
        n = $urandom(32'h20130a6d);
        for (int i = 0; i < 5; i++) begin
            u_cpu.io_read(6'(OFS_CONTROL + i[5:0]), rd);
            check(rd, 8'h00);
        end
        u_cpu.io_write(OFS_ADDRESS_HIGH, 8'hff);
        u_cpu.io_read(OFS_ADDRESS_HIGH, rd);
        check(rd, 8'h01);
        u_cpu.io_write(OFS_CONTROL, 8'hf0);
        u_cpu.io_read(OFS_CONTROL, rd);
        check(rd, 8'h00);
        $display("Test reset values done");
        for (int i = 0; i < 6; i++) begin
            a = (i == 0) ? 0 : (i == 1) ? 511 : $urandom_range(2, 510);
            nv_write(a, 8'($urandom));
            nv_read(a);
        end
        nv_read(0);
        $display("Test write and read done");
        u_cpu.io_write(OFS_DATA, ~mem[511]);
        u_cpu.io_write(OFS_CONTROL, 8'h02);
        #1 check({7'h00, write_busy}, 8'h00);
        nv_read(511);
        $display("Test unguarded strobe done");
        u_cpu.io_write(OFS_CONTROL, 8'h04);
        u_cpu.io_read(OFS_CONTROL, rd);
        check(rd, 8'h04);
        repeat (4) @(posedge core_clk);
        u_cpu.io_read(OFS_CONTROL, rd);
        check(rd, 8'h00);
        u_cpu.io_write(OFS_DATA, ~mem[511]);
        u_cpu.io_write(OFS_CONTROL, 8'h02);
        #1 check({7'h00, write_busy}, 8'h00);
        nv_read(511);
        $display("Test enable timeout done");
        finish_test();
    end
endmodule : test_eeprom_cpu_access_port
